/* hdl/udr_params.svh */
`ifndef UDR_PARAMS_SVH
`define UDR_PARAMS_SVH
// ============================================================
// Descriptor type codes
`define UDR_TYPE_CONFIG 8'h02
`define UDR_TYPE_STRING 8'h03
`define UDR_TYPE_ENDPT 8'h05
`define UDR_TYPE_QUAL 8'h06
`define UDR_TYPE_OSCFG 8'h07
// ============================================================
// Endpoint descriptor constants
`define UDR_EP_LEN 8'h07
`define UDR_EP2_ADDR 8'h02
`define UDR_EP2_ATTR 8'h02
`define UDR_EP2_IVAL 8'h00
`define UDR_EP2_MPS_HS 16'h0200
`define UDR_EP2_MPS_FS 16'h0040
`define UDR_EP3_ADDR 8'h83
`define UDR_EP3_ATTR 8'h03
`define UDR_EP3_MPS 16'h0010
`define UDR_EP3_IVAL_DEF 8'h04
// ============================================================
// Other-speed configuration constants
`define UDR_OSC_LEN 8'h09
`define UDR_OSC_TOTAL 16'h0027
`define UDR_OSC_NIF 8'h01
`define UDR_OSC_CFGVAL 8'h01
`define UDR_OSC_ATTR_DEF 8'ha0
`define UDR_ATTR_WAKE_BIT 5
`define UDR_PWR_SELF 8'h01
`define UDR_PWR_BUS 8'hfa
// ============================================================
// Device qualifier constants
`define UDR_QUAL_LEN 8'h0a
`define UDR_QUAL_BCD 16'h0200
`define UDR_QUAL_CLASS 8'hff
`define UDR_QUAL_SUB 8'h00
`define UDR_QUAL_PROTO 8'hff
`define UDR_QUAL_MPS0 8'h40
`define UDR_QUAL_NCFG 8'h01
`define UDR_QUAL_RSVD 8'h00
// ============================================================
// Language-ID string
`define UDR_LANG_LEN 8'h04
`define UDR_LANG_EE_ADDR 8'h0a
`define UDR_NUM_STRINGS 5
// ============================================================
// Selectors of the descriptor to send
`define UDR_SEL_EP2 3'h0
`define UDR_SEL_EP3 3'h1
`define UDR_SEL_OSC 3'h2
`define UDR_SEL_QUAL 3'h3
`define UDR_SEL_STR0 3'h4
`define UDR_SEL_STRN 3'h5
`endif

/* hdl/udr_pkg.sv */
package udr_pkg;
	// Responder sequencer states, one-hot
	typedef enum logic [2:0] {
		UDR_IDLE = 3'b001,
		UDR_SEND = 3'b010,
		UDR_STALL = 3'b100
	} udr_state_t;
endpackage

/* hdl/udr_responder.sv */
`timescale 1ns/1ps
`include "udr_params.svh"
module udr_responder (
	// Clock and reset
	input wire logic MCLK_IN,
	input wire logic NRST_IN,
	// Strap pins
	input wire logic REMOTE_WAKEUP_STRAP_IN,
	input wire logic SELF_POWERED_IN,
	// Speed and EEPROM loader state
	input wire logic HIGH_SPEED_IN,
	input wire logic EE_VALID_IN,
	input wire logic EE_ANY_STRING_IN,
	input wire logic [4:0] EE_STR_PRESENT_IN,
	input wire logic [7:0] EE_EP3_IVAL_IN,
	input wire logic [7:0] EE_HS_CFG_IDX_IN,
	input wire logic [7:0] EE_FS_CFG_IDX_IN,
	input wire logic [7:0] EE_HS_CFG_ATTR_IN,
	input wire logic [7:0] EE_FS_CFG_ATTR_IN,
	input wire logic [7:0] EE_HS_CFG_PWR_IN,
	input wire logic [7:0] EE_FS_CFG_PWR_IN,
	input wire logic [23:0] EE_HS_DEV_CLASS_IN,
	input wire logic [23:0] EE_FS_DEV_CLASS_IN,
	input wire logic [15:0] EE_LANGID_IN,
	// Request from control endpoint logic
	input wire logic REQ_IN,
	input wire logic [2:0] REQ_SEL_IN,
	input wire logic [2:0] REQ_STR_IDX_IN,
	input wire logic [15:0] REQ_LANGID_IN,
	input wire logic [15:0] REQ_LEN_IN,
	input wire logic BYTE_READY_IN,
	// Answer
	output logic BYTE_VALID_OUT,
	output logic [7:0] BYTE_DATA_OUT,
	output logic BYTE_LAST_OUT,
	output logic STALL_OUT,
	output logic BUSY_OUT
);
	// Synchronised strap levels
	logic wake_s;
	logic selfp_s;
	udr_sync2 u_sync_wake (
		.clk_in(MCLK_IN),
		.d_in(REMOTE_WAKEUP_STRAP_IN),
		.q_out(wake_s)
	);
	udr_sync2 u_sync_pwr (
		.clk_in(MCLK_IN),
		.d_in(SELF_POWERED_IN),
		.q_out(selfp_s)
	);

	// ============================================================
	// State
	typedef struct packed {
		udr_pkg::udr_state_t st;
		logic [79:0] buf_d; // Descriptor bytes, byte 0 low
		logic [7:0] idx; // Bytes presented so far, i.e. offset of the next byte
		logic [7:0] cnt; // Bytes to send
		logic valid;
		logic [7:0] data;
		logic last;
		logic stall;
		logic busy;
	} udr_st_t;
	udr_st_t s_r;
	udr_st_t s_nxt;

	// Assembled descriptor images
	logic [79:0] img;
	logic [7:0] img_len;
	logic img_stall;
	logic [7:0] attr_def;
	logic [7:0] pwr_def;
	logic [7:0] osc_attr;
	logic [7:0] osc_pwr;
	logic [7:0] osc_idx;
	logic [23:0] qual_cls;
	logic [15:0] ep2_mps;
	logic [7:0] ep3_ival;
	logic [7:0] len_cap;

	// ============================================================
	// Descriptor image builder
	always_comb begin
		// Strap level stands in for the default's wake bit; EEPROM values pass untouched
		attr_def = `UDR_OSC_ATTR_DEF;
		attr_def[`UDR_ATTR_WAKE_BIT] = wake_s;
		pwr_def = selfp_s ? `UDR_PWR_SELF : `UDR_PWR_BUS;
		// Opposite speed values picked here
		if (HIGH_SPEED_IN) begin
			osc_attr = EE_FS_CFG_ATTR_IN;
			osc_pwr = EE_FS_CFG_PWR_IN;
			osc_idx = EE_FS_CFG_IDX_IN;
			qual_cls = EE_FS_DEV_CLASS_IN;
		end else begin
			osc_attr = EE_HS_CFG_ATTR_IN;
			osc_pwr = EE_HS_CFG_PWR_IN;
			osc_idx = EE_HS_CFG_IDX_IN;
			qual_cls = EE_HS_DEV_CLASS_IN;
		end
		// No EEPROM: fall back to hardware defaults
		if (!EE_VALID_IN) begin
			osc_attr = attr_def;
			osc_pwr = pwr_def;
			osc_idx = 8'h00;
			qual_cls = {`UDR_QUAL_PROTO, `UDR_QUAL_SUB, `UDR_QUAL_CLASS};
		end
		ep2_mps = HIGH_SPEED_IN ? `UDR_EP2_MPS_HS : `UDR_EP2_MPS_FS;
		ep3_ival = EE_VALID_IN ? EE_EP3_IVAL_IN : `UDR_EP3_IVAL_DEF;
		img = 80'h0;
		img_len = 8'h00;
		img_stall = 1'b0;
		// Requested language identifier deliberately unused
		case (REQ_SEL_IN)
			`UDR_SEL_EP2: begin
				img[55:0] = {`UDR_EP2_IVAL, ep2_mps, `UDR_EP2_ATTR, `UDR_EP2_ADDR,
					`UDR_TYPE_ENDPT, `UDR_EP_LEN};
				img_len = `UDR_EP_LEN;
			end
			`UDR_SEL_EP3: begin
				img[55:0] = {ep3_ival, `UDR_EP3_MPS, `UDR_EP3_ATTR, `UDR_EP3_ADDR,
					`UDR_TYPE_ENDPT, `UDR_EP_LEN};
				img_len = `UDR_EP_LEN;
			end
			`UDR_SEL_OSC: begin
				img[71:0] = {osc_pwr, osc_attr, osc_idx, `UDR_OSC_CFGVAL, `UDR_OSC_NIF,
					`UDR_OSC_TOTAL, `UDR_TYPE_OSCFG, `UDR_OSC_LEN};
				img_len = `UDR_OSC_LEN;
			end
			`UDR_SEL_QUAL: begin
				img = {`UDR_QUAL_RSVD, `UDR_QUAL_NCFG, `UDR_QUAL_MPS0, qual_cls,
					`UDR_QUAL_BCD, `UDR_TYPE_QUAL, `UDR_QUAL_LEN};
				img_len = `UDR_QUAL_LEN;
			end
			`UDR_SEL_STR0: begin
				img[31:0] = {EE_LANGID_IN, `UDR_TYPE_STRING, `UDR_LANG_LEN};
				img_len = `UDR_LANG_LEN;
				img_stall = !EE_VALID_IN || !EE_ANY_STRING_IN;
			end
			`UDR_SEL_STRN: begin
				// Contents come from elsewhere; only presence is judged here
				img_stall = !EE_VALID_IN || (REQ_STR_IDX_IN == 3'h0) ||
					(REQ_STR_IDX_IN > 3'h5) || !EE_STR_PRESENT_IN[REQ_STR_IDX_IN - 3'h1];
			end
			default: begin
				img_stall = 1'b1;
			end
		endcase
		len_cap = (REQ_LEN_IN < {8'h00, img_len}) ? REQ_LEN_IN[7:0] : img_len;
	end

	// ============================================================
	// Sequencer
	always_comb begin
		s_nxt = s_r;
		s_nxt.valid = 1'b0;
		s_nxt.last = 1'b0;
		s_nxt.stall = 1'b0;
		case (s_r.st)
			udr_pkg::UDR_IDLE: begin
				s_nxt.busy = 1'b0;
				if (REQ_IN) begin
					s_nxt.busy = 1'b1;
					s_nxt.buf_d = img;
					s_nxt.idx = 8'h00;
					s_nxt.cnt = len_cap;
					if (img_stall) begin
						s_nxt.st = udr_pkg::UDR_STALL;
					end else if (len_cap == 8'h00) begin
						s_nxt.busy = 1'b0;
					end else begin
						s_nxt.st = udr_pkg::UDR_SEND;
					end
				end
			end
			udr_pkg::UDR_SEND: begin
				// Present byte at current offset until accepted
				if (!s_r.valid || BYTE_READY_IN) begin
					if (s_r.valid && s_r.last) begin
						s_nxt.st = udr_pkg::UDR_IDLE;
						s_nxt.busy = 1'b0;
					end else begin
						s_nxt.valid = 1'b1;
						s_nxt.data = s_r.buf_d[7:0];
						s_nxt.buf_d = {8'h00, s_r.buf_d[79:8]};
						s_nxt.idx = s_r.idx + 8'h01;
						s_nxt.last = (s_r.idx + 8'h01 == s_r.cnt);
					end
				end else begin
					s_nxt.valid = 1'b1;
					s_nxt.last = s_r.last;
				end
			end
			udr_pkg::UDR_STALL: begin
				// One-cycle stall pulse
				s_nxt.stall = 1'b1;
				s_nxt.busy = 1'b0;
				s_nxt.st = udr_pkg::UDR_IDLE;
			end
			default: begin
				s_nxt.st = udr_pkg::UDR_IDLE;
			end
		endcase
	end

	// Synchronous active-low reset
	always_ff @(posedge MCLK_IN) begin
		if (!NRST_IN) begin
			s_r <= '{st: udr_pkg::UDR_IDLE, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign BYTE_VALID_OUT = s_r.valid;
	assign BYTE_DATA_OUT = s_r.data;
	assign BYTE_LAST_OUT = s_r.last;
	assign STALL_OUT = s_r.stall;
	assign BUSY_OUT = s_r.busy;

	// ============================================================
	// Checks
	a_ep2_type: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_EP2) |-> (img[15:0] == 16'h0507 && img[31:16] == 16'h0202))
		else $error("bulk-out header wrong");
	a_ep2_mps: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_EP2 && HIGH_SPEED_IN) |-> img[47:32] == 16'h0200)
		else $error("bulk-out max packet wrong");
	a_ep3_fixed: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_EP3) |-> img[47:0] == 48'h0010_0383_0507)
		else $error("interrupt endpoint wrong");
	a_ep3_ival: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_EP3 && !EE_VALID_IN) |-> img[55:48] == 8'h04)
		else $error("interrupt interval default wrong");
	a_osc_head: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_OSC) |-> img[47:0] == 48'h0101_0027_0709)
		else $error("other-speed header wrong");
	a_osc_pick: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_OSC && EE_VALID_IN && HIGH_SPEED_IN) |-> img[71:64] == EE_FS_CFG_PWR_IN)
		else $error("other-speed picked wrong speed");
	a_osc_power: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_OSC && !EE_VALID_IN) |-> img[71:64] == (selfp_s ? 8'h01 : 8'hfa))
		else $error("power default wrong");
	a_qual_tail: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_QUAL) |-> (img[15:0] == 16'h060a && img[79:72] == 8'h00))
		else $error("qualifier frame wrong");
	a_lang_stall: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(s_r.st == udr_pkg::UDR_IDLE && REQ_IN && REQ_SEL_IN == `UDR_SEL_STR0 && !EE_VALID_IN)
		|=> ##1 STALL_OUT)
		else $error("language stall missing");
	a_trunc_len: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(BYTE_VALID_OUT && BYTE_LAST_OUT) |-> s_r.idx == s_r.cnt)
		else $error("last byte at wrong offset");
	// ============================================================
	// Field and handshake checks
	a_ep2_ival: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_EP2) |-> img[55:48] == 8'h00)
		else $error("bulk-out interval not zero");
	a_osc_hs_pick: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_OSC && EE_VALID_IN && !HIGH_SPEED_IN) |->
		img[71:56] == {EE_HS_CFG_PWR_IN, EE_HS_CFG_ATTR_IN})
		else $error("other-speed picked wrong speed at full speed");
	a_osc_attr: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_OSC && !EE_VALID_IN) |-> img[63:56] == {2'b10, wake_s, 5'h00})
		else $error("attributes default wrong");
	a_qual_dflt: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_QUAL && !EE_VALID_IN) |-> img[71:16] == 56'h0140ff00ff0200)
		else $error("qualifier defaults wrong");
	a_qual_pick: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_QUAL && EE_VALID_IN && !HIGH_SPEED_IN) |-> img[55:32] == EE_HS_DEV_CLASS_IN)
		else $error("qualifier picked wrong speed");
	a_lang_body: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(REQ_SEL_IN == `UDR_SEL_STR0) |-> img[31:0] == {EE_LANGID_IN, 16'h0304})
		else $error("language string wrong");
	a_strn_stall: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(s_r.st == udr_pkg::UDR_IDLE && REQ_IN && REQ_SEL_IN == `UDR_SEL_STRN && !EE_VALID_IN)
		|=> ##1 STALL_OUT)
		else $error("string stall missing");
	// A refused byte must stand unchanged at the next edge
	a_byte_hold: assert property (@(posedge MCLK_IN) disable iff (!NRST_IN)
		(BYTE_VALID_OUT && !BYTE_READY_IN) |=> (BYTE_VALID_OUT && $stable(BYTE_DATA_OUT)))
		else $error("refused byte not held");
endmodule // udr_responder

/* hdl/udr_sync2.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for one pin level
module udr_sync2 (
	input wire logic clk_in,
	input wire logic d_in,
	output logic q_out
);
	typedef struct packed {
		logic s1; // First stage, read only by second
		logic s2; // Second stage, safe to use
	} udr_sync_st_t;
	udr_sync_st_t st_r;
	udr_sync_st_t st_nxt;
	// ============================================================
	// Shift
	always_comb begin
		st_nxt.s1 = d_in;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge clk_in) begin
		st_r <= st_nxt;
	end
	assign q_out = st_r.s2;
endmodule // udr_sync2

/* tb/tb_udr_responder.sv */
`timescale 1ns/1ps
// ============================================================
// Bench for the descriptor responder
module tb_udr_responder;
	logic MCLK_IN = 1'b0; // 20 MHz
	logic NRST_IN = 1'b0; // Sync, active low
	integer seed = 32'h7bf9;
	integer err_total = 0;
	integer checks = 0;
	integer cyc = 0;
	integer i, k, n;
	logic wake = 0, selfp = 0, hs = 0, eev = 0, eeany = 0, req = 0, st;
	logic [4:0] pres = 0;
	logic [7:0] ival = 0, hidx = 0, fidx = 0, hattr = 0, fattr = 0, hpwr = 0, fpwr = 0, at, pw, ix;
	logic [23:0] hcls = 0, fcls = 0, c;
	logic [15:0] lang = 16'h0409, rlang = 0, rlen = 0; // Stored language value
	logic [2:0] sel = 0, sidx = 1;
	logic [127:0] r;
	logic [79:0] v; // Descriptor, offset 0 in the top byte
	logic bvalid, blast, stall, busy, ready;
	logic [7:0] bdata;
	logic [9:0] expq[$]; // Notes: {stall, last, byte}
	udr_responder DUT (.MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN), .REMOTE_WAKEUP_STRAP_IN(wake),
		.SELF_POWERED_IN(selfp), .HIGH_SPEED_IN(hs), .EE_VALID_IN(eev), .EE_ANY_STRING_IN(eeany),
		.EE_STR_PRESENT_IN(pres), .EE_EP3_IVAL_IN(ival), .EE_HS_CFG_IDX_IN(hidx), .EE_FS_CFG_IDX_IN(fidx),
		.EE_HS_CFG_ATTR_IN(hattr), .EE_FS_CFG_ATTR_IN(fattr), .EE_HS_CFG_PWR_IN(hpwr),
		.EE_FS_CFG_PWR_IN(fpwr), .EE_HS_DEV_CLASS_IN(hcls), .EE_FS_DEV_CLASS_IN(fcls),
		.EE_LANGID_IN(lang), .REQ_IN(req), .REQ_SEL_IN(sel), .REQ_STR_IDX_IN(sidx),
		.REQ_LANGID_IN(rlang), .REQ_LEN_IN(rlen), .BYTE_READY_IN(ready), .BYTE_VALID_OUT(bvalid),
		.BYTE_DATA_OUT(bdata), .BYTE_LAST_OUT(blast), .STALL_OUT(stall), .BUSY_OUT(busy));
	udr_host_model host (.clk_in(MCLK_IN), .ready_out(ready));
	always #25 MCLK_IN = ~MCLK_IN;
	// ============================================================
	// Compare and close
	task chk(input logic [9:0] e, input logic [9:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task conclude;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ============================================================
	// Expected answer; opposite speed for cfg and qualifier
	task build;
		st = 1'b0;
		n = 0;
		v = 80'h0;
		ix = eev ? (hs ? fidx : hidx) : 8'h00;
		at = eev ? (hs ? fattr : hattr) : 8'ha0;
		if (!eev)
			at[5] = wake; // Strap shapes only the default
		pw = eev ? (hs ? fpwr : hpwr) : (selfp ? 8'h01 : 8'hfa);
		c = eev ? (hs ? fcls : hcls) : 24'hff00ff;
		case (sel)
			3'd0: begin v = {16'h0705, 16'h0202, hs ? 16'h0002 : 16'h4000, 8'h00, 24'h0}; n = 7; end
			3'd1: begin v = {32'h07058303, 16'h1000, eev ? ival : 8'h04, 24'h0}; n = 7; end
			3'd2: begin v = {48'h090727000101, ix, at, pw, 8'h00}; n = 9; end
			3'd3: begin v = {32'h0a060002, c[7:0], c[15:8], c[23:16], 24'h400100}; n = 10; end
			3'd4: begin
				st = !(eev && eeany);
				v = {16'h0403, lang[7:0], lang[15:8], 48'h0};
				n = st ? 0 : 4;
			end
			3'd5: st = !eev || sidx == 3'd0 || sidx > 3'd5 || !pres[sidx - 3'd1];
			default: st = 1'b1;
		endcase
		if (rlen < 16'(n))
			n = int'(rlen);
		if (st)
			expq.push_back(10'h200);
		for (k = 0; k < n; k++)
			expq.push_back({1'b0, k == n - 1, v[79 - 8 * k -: 8]});
	endtask
	// ============================================================
	// Watcher: oldest note against each accepted byte or stall
	always @(posedge MCLK_IN) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
		if (NRST_IN && ((bvalid === 1'b1 && ready === 1'b1) || stall === 1'b1)) begin
			if (expq.size() == 0) begin
				err_total++;
				$display("Error %0t: unexpected answer", $time);
			end else
				chk(expq.pop_front(), stall ? 10'h200 : {1'b0, blast, bdata});
		end
	end
	// ============================================================
	// Driver: all selectors, both speeds, random EEPROM image and lengths
	initial begin
		repeat (6) @(negedge MCLK_IN);
		NRST_IN = 1'b1;
		repeat (3) @(negedge MCLK_IN);
		chk(10'h000, {7'h0, bvalid, stall, busy}); // Idle after reset
		for (i = 0; i < 120; i++) begin
			r = {$random(seed), $random(seed), $random(seed), $random(seed)}; // Free fields only
			{hcls, fcls, ival, hidx, fidx, hattr, fattr, hpwr, fpwr} = r[103:0];
			{wake, selfp, hs, eev, eeany, pres} = r[114:105];
			sel = 3'(i % 8);
			sidx = 3'($random(seed)); // Out-of-range indices too
			rlang = $random(seed); // Never looked at
			rlen = (i % 3 == 0) ? 16'($unsigned($random(seed)) % 12) : 16'hffff;
			repeat (3) @(negedge MCLK_IN); // Straps settle
			build();
			req = 1'b1;
			@(negedge MCLK_IN);
			req = 1'b0;
			repeat (3) @(negedge MCLK_IN);
			// Mid-transfer request must be ignored
			if (busy === 1'b1) begin
				req = 1'b1;
				@(negedge MCLK_IN);
				req = 1'b0;
			end
			k = 0;
			while (busy !== 1'b0 && k < 200) begin
				@(negedge MCLK_IN);
				k++;
			end
			if (k == 200)
				err_total++; // Hung transfer counts as a mismatch
			@(negedge MCLK_IN);
		end
		chk(10'h000, 10'(expq.size())); // Every expected answer arrived
		conclude();
	end
endmodule // tb_udr_responder

/* tb/udr_host_model.sv */
`timescale 1ns/1ps
// ============================================================
// Host side of the data stage: takes bytes, stalls at random
module udr_host_model (
	// Clock
	input wire logic clk_in,
	// Accept strobe towards the responder
	output logic ready_out
);
	integer seed = 32'h7bf9; // Fixed seed, own stream
	initial ready_out = 1'b0;
	// About one edge in three refuses, so held bytes get exercised
	always @(negedge clk_in) begin
		ready_out <= ($random(seed) % 3) != 0;
	end
endmodule // udr_host_model
